// ==== rtl/sfs_spi_frame_sequencer.sv ====
`timescale 1ns/1ps

module sfs_spi_frame_sequencer (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // apb slave
  input  wire logic [sfs_pkg::APB_AW-1:0] paddr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // serial link
  input  wire logic                      serial_clock_in,
  input  wire logic                      frame_select_in,
  input  wire logic                      rx_serial_line,
  output logic                           serial_clock_out,
  output logic                           frame_select_out,
  output logic                           tx_serial_line,
  output logic                           tx_pad_enable_n,
  output logic                           clock_pad_enable_n
);
  import sfs_pkg::*;

  logic [CTRL_W-1:0] ctrl_q;
  logic [15:0]       tx_data_q;
  logic [15:0]       rx_data_q;
  logic [15:0]       shreg_q;
  logic [15:0]       rx_sh_q;
  logic              tx_full_q;
  logic              rx_valid_q;
  logic [31:0]       prdata_q;
  logic              pready_q;
  logic              pslverr_q;
  sfs_state_t        state_q;
  sfs_state_t        st_d;
  logic [5:0]        ecnt_q;
  logic [7:0]        div_cnt_q;
  logic              sclk_q;
  logic              fss_q;
  logic              txd_q;
  logic              txoe_n_q;
  logic              ckoe_n_q;
  logic              sck_s1, sck_s2, sck_s3;
  logic              fs_s1, fs_s2, fs_s3;
  logic              rx_s1, rx_s2;
  logic [3:0]        bcnt_q;
  logic              s_first_q;
  logic              s_wrap_q;
  logic [31:0]       stat_w;
  logic [31:0]       rd_mux;

  // control fields
  wire       en_w   = ctrl_q[EN_POS];
  wire       ms_w   = ctrl_q[MS_POS];
  wire       pol_w  = ctrl_q[POL_POS];
  wire       pha_w  = ctrl_q[PHA_POS];
  wire [7:0] div_w  = ctrl_q[DIV_MSB:DIV_LSB];
  wire [3:0] dss_r  = ctrl_q[DSS_MSB:DSS_LSB];
  wire [3:0] dss_w  = (dss_r < DSS_MIN) ? DSS_MIN : dss_r;

  // apb decode; no wait state, prdata comes from a flop loaded in the setup cycle
  wire apb_setup = psel & ~penable;
  wire apb_acc   = psel & penable & pready_q;
  wire wr_en     = apb_acc & pwrite;
  wire rd_en     = apb_acc & ~pwrite;
  wire hit_ctrl  = (paddr == CTRL_OFS);
  wire hit_stat  = (paddr == STAT_OFS);
  wire hit_txd   = (paddr == TXD_OFS);
  wire hit_rxd   = (paddr == RXD_OFS);
  wire hit_any   = hit_ctrl | hit_stat | hit_txd | hit_rxd;

  // word geometry in half periods
  wire [4:0]  word_n   = {1'b0, dss_w} + 5'h01;
  wire [5:0]  two_n    = {word_n, 1'b0};
  wire [5:0]  two_n_p1 = two_n + E_STEP;
  wire [5:0]  end_pos  = two_n + E_TAIL;
  wire [3:0]  align    = DSS_TOP - dss_w;
  wire [15:0] tx_align = tx_full_q ? 16'(tx_data_q << align) : 16'h0000;
  wire [15:0] word_msk = 16'hFFFF >> align;

  // master sequencing strobes
  wire       m_ok      = en_w & ~ms_w;
  wire       m_tick    = (state_q != ST_IDLE) & (div_cnt_q == div_w);
  wire       m_rtick   = (state_q == ST_RUN) & m_tick;
  wire [5:0] e_nxt     = ecnt_q + E_STEP;
  wire       m_end     = m_rtick & (e_nxt == end_pos);
  wire       m_cont    = pha_w & tx_full_q;
  wire       m_more    = ~pha_w & tx_full_q;
  wire [5:0] e_eff     = (m_end & m_cont) ? E_LOAD : e_nxt;
  wire       m_load    = m_rtick & (e_eff == E_LOAD);
  wire       m_edge_p1 = (e_eff >= E_LOAD) & (e_eff <= two_n);
  wire       m_edge_p0 = (e_eff >= E_FIRST_CAP) & (e_eff <= two_n_p1);
  wire       m_edge    = m_rtick & (pha_w ? m_edge_p1 : m_edge_p0);
  wire       m_shift   = m_rtick & e_eff[0] & (e_eff >= E_FIRST_SHIFT)
                         & (e_eff < two_n);
  wire       m_cap     = m_rtick & ~e_eff[0] & (e_eff >= E_FIRST_CAP)
                         & (e_eff <= two_n);

  // slave strobes from the synchronised link pins
  wire s_ok     = en_w & ms_w;
  wire s_sel    = s_ok & ~fs_s2;
  wire s_fall   = s_ok & fs_s3 & ~fs_s2;
  wire s_edge   = s_sel & (sck_s2 ^ sck_s3);
  wire s_lead   = s_edge & (sck_s2 != pol_w);
  wire s_trail  = s_edge & (sck_s2 == pol_w);
  wire s_cap    = pha_w ? s_trail : s_lead;
  wire s_shedge = pha_w ? s_lead : s_trail;
  wire s_end    = s_cap & (bcnt_q == dss_w);
  wire s_load   = s_fall | (s_shedge & s_wrap_q & pha_w);
  wire s_shift  = s_shedge & ~s_first_q & ~s_wrap_q;

  // shared datapath strobes
  wire        any_load  = m_load | s_load;
  wire        any_shift = m_shift | s_shift;
  wire        any_cap   = m_cap | s_cap;
  wire        word_end  = m_end | s_end;
  wire        consume   = any_load & tx_full_q;
  wire [15:0] cap_new   = {rx_sh_q[14:0], rx_s2};
  wire [15:0] rx_store  = s_end ? cap_new : rx_sh_q;

  // status and read mux
  always_comb
  begin
    stat_w              = 32'h0000_0000;
    stat_w[ST_BUSY_POS] = (state_q != ST_IDLE);
    stat_w[ST_TXF_POS]  = tx_full_q;
    stat_w[ST_RXV_POS]  = rx_valid_q;
    stat_w[ST_SEL_POS]  = s_sel;
  end

  assign rd_mux = hit_ctrl ? {16'h0000, ctrl_q} :
                  hit_stat ? stat_w :
                  hit_txd  ? {16'h0000, tx_data_q} :
                  hit_rxd  ? {16'h0000, rx_data_q} : 32'h0000_0000;

  // apb answer flops
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= apb_setup;
      pslverr_q <= apb_setup & ~hit_any;
      prdata_q  <= apb_setup ? rd_mux : 32'h0000_0000;
    end
  end

  // software registers; a hardware set beats a same-cycle clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q     <= CTRL_RST;
      tx_data_q  <= 16'h0000;
      tx_full_q  <= 1'b0;
      rx_valid_q <= 1'b0;
      rx_data_q  <= 16'h0000;
    end
    else
    begin
      if (wr_en & hit_ctrl)
        ctrl_q <= pwdata[CTRL_W-1:0];
      if (wr_en & hit_txd)
        tx_data_q <= pwdata[15:0];
      tx_full_q  <= (wr_en & hit_txd) | (tx_full_q & ~consume);
      rx_valid_q <= word_end | (rx_valid_q & ~(rd_en & hit_rxd));
      if (word_end)
        rx_data_q <= rx_store & word_msk;
    end
  end

  // link pins pass two flops; the third stage only feeds edge detect
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {sck_s1, sck_s2, sck_s3} <= 3'h0;
      {fs_s1, fs_s2, fs_s3}    <= 3'h7;
      {rx_s1, rx_s2}           <= 2'h0;
    end
    else
    begin
      {sck_s1, sck_s2, sck_s3} <= {serial_clock_in, sck_s1, sck_s2};
      {fs_s1, fs_s2, fs_s3}    <= {frame_select_in, fs_s1, fs_s2};
      {rx_s1, rx_s2}           <= {rx_serial_line, rx_s1};
    end
  end

  // master frame state machine
  always_comb
  begin
    case (state_q)
      ST_IDLE: st_d = tx_full_q ? ST_RUN : ST_IDLE;
      ST_RUN:  st_d = (m_end & ~m_cont) ?
                      (m_more ? ST_GAP : ST_IDLE) : ST_RUN;
      ST_GAP:  st_d = m_tick ? ST_RUN : ST_GAP;
      default: st_d = ST_IDLE;
    endcase
    if (!m_ok)
      st_d = ST_IDLE;
  end

  // half-period divider and position counter
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q   <= ST_IDLE;
      ecnt_q    <= 6'h00;
      div_cnt_q <= 8'h00;
    end
    else
    begin
      state_q   <= st_d;
      div_cnt_q <= (m_tick | (st_d != state_q)) ? 8'h00 : div_cnt_q + 8'h01;
      if (st_d != ST_RUN || state_q != ST_RUN)
        ecnt_q <= 6'h00;
      else if (m_tick)
        ecnt_q <= e_eff;
    end
  end

  // slave bit tracking
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bcnt_q    <= 4'h0;
      s_first_q <= 1'b0;
      s_wrap_q  <= 1'b0;
    end
    else if (s_fall)
    begin
      bcnt_q    <= 4'h0;
      s_first_q <= pha_w; // first phase-1 edge only launches data
      s_wrap_q  <= 1'b0;
    end
    else
    begin
      if (s_cap)
        bcnt_q <= s_end ? 4'h0 : bcnt_q + 4'h1;
      if (s_shedge)
        s_first_q <= 1'b0;
      s_wrap_q <= s_end | (s_wrap_q & ~s_shedge);
    end
  end

  // shifters, msb leaves first
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shreg_q <= 16'h0000;
      rx_sh_q <= 16'h0000;
    end
    else
    begin
      if (any_load)
        shreg_q <= tx_align;
      else if (any_shift)
        shreg_q <= {shreg_q[14:0], 1'b0};
      if (any_cap)
        rx_sh_q <= cap_new;
    end
  end

  // pin drivers, all registered
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclk_q   <= 1'b0;
      fss_q    <= 1'b1;
      txd_q    <= 1'b0;
      txoe_n_q <= 1'b1;
      ckoe_n_q <= 1'b0;
    end
    else
    begin
      sclk_q   <= m_edge ? ~sclk_q : (m_rtick | (state_q == ST_RUN))
                  ? sclk_q : pol_w;
      fss_q    <= ms_w | (st_d != ST_RUN);
      ckoe_n_q <= ms_w;
      txoe_n_q <= ms_w ? ~s_sel : (st_d == ST_IDLE);
      if (any_load)
        txd_q <= tx_align[15];
      else if (any_shift)
        txd_q <= shreg_q[14];
      else if (st_d == ST_IDLE && !s_sel)
        txd_q <= 1'b0;
    end
  end

  assign prdata             = prdata_q;
  assign pready             = pready_q;
  assign pslverr            = pslverr_q;
  assign serial_clock_out   = sclk_q;
  assign frame_select_out   = fss_q;
  assign tx_serial_line     = txd_q;
  assign tx_pad_enable_n    = txoe_n_q;
  assign clock_pad_enable_n = ckoe_n_q;

  // checks on the sequencer
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_open;
    (state_q == ST_IDLE) && (st_d == ST_RUN) ##1 !fss_q && !txoe_n_q;
  endsequence

  a_idle_pins: assert property (
    (state_q == ST_IDLE) && $past(state_q == ST_IDLE) && !fs_s3 == 1'b0
    && !s_sel && $past(!s_sel) |-> fss_q && !txd_q && txoe_n_q)
    else $error("idle pin levels wrong");
  a_idle_clock: assert property (
    m_ok && $stable(pol_w) && (state_q == ST_IDLE) && $past(state_q == ST_IDLE)
    |-> sclk_q == pol_w)
    else $error("idle clock not at polarity");
  a_clock_pad: assert property (
    ##1 ckoe_n_q == $past(ms_w))
    else $error("clock pad enable not following mode");
  a_start_frame: assert property (
    (state_q == ST_IDLE) && (st_d == ST_RUN) |-> s_open)
    else $error("frame did not open");
  a_ph0_delay: assert property (
    m_load && !pha_w |=> $stable(sclk_q))
    else $error("phase 0 clock moved with first data");
  a_ph1_edge: assert property (
    m_load && pha_w |=> sclk_q != $past(sclk_q))
    else $error("phase 1 clock did not start with data");
  a_select_end: assert property (
    m_end && !m_cont |=> fss_q ##1 (fss_q || state_q == ST_RUN))
    else $error("select not released after last capture");
  a_gap_pulse: assert property (
    (state_q == ST_GAP) |-> fss_q)
    else $error("select low between phase 0 words");
  a_ph1_hold: assert property (
    m_end && m_cont && m_ok |=> !fss_q)
    else $error("select rose between phase 1 words");
  a_msb_out: assert property (
    any_load |=> txd_q == $past(tx_align[15]))
    else $error("first bit out is not the msb");

endmodule : sfs_spi_frame_sequencer

// ==== rtl/sfs_pkg.sv ====
package sfs_pkg;

  // register map, byte addresses on the apb bus
  localparam int          APB_AW   = 12;
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;
  localparam logic [11:0] TXD_OFS  = 12'h008;
  localparam logic [11:0] RXD_OFS  = 12'h00C;

  // control register layout
  localparam int          CTRL_W   = 16;
  localparam int          EN_POS   = 0;
  localparam int          MS_POS   = 1;
  localparam int          POL_POS  = 2;
  localparam int          PHA_POS  = 3;
  localparam int          DSS_LSB  = 4;
  localparam int          DSS_MSB  = 7;
  localparam int          DIV_LSB  = 8;
  localparam int          DIV_MSB  = 15;
  localparam logic [15:0] CTRL_RST = 16'h0070;

  // status register layout
  localparam int ST_BUSY_POS = 0;
  localparam int ST_TXF_POS  = 1;
  localparam int ST_RXV_POS  = 2;
  localparam int ST_SEL_POS  = 3;

  // word size field holds length minus one
  localparam int         WORD_MAX = 16;
  localparam logic [3:0] DSS_MIN  = 4'h3;
  localparam logic [3:0] DSS_TOP  = 4'hF;

  // half-period positions inside one word
  localparam logic [5:0] E_STEP        = 6'h01;
  localparam logic [5:0] E_LOAD        = 6'h01;
  localparam logic [5:0] E_FIRST_CAP   = 6'h02;
  localparam logic [5:0] E_FIRST_SHIFT = 6'h03;
  localparam logic [5:0] E_TAIL        = 6'h02;

  localparam int CLK_PERIOD_NS = 100;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_GAP} sfs_state_t;

endpackage : sfs_pkg

// ==== sim/sfs_slave_model.sv ====
`timescale 1ns/1ps

// off-chip slave, reacting to the wires without a clock of its own
module sfs_slave_model (
  // link wires
  input  wire logic        sclk,
  input  wire logic        ss_n,
  input  wire logic        mosi,
  output logic             miso,
  // setup from the bench
  input  wire logic        pol,
  input  wire logic        pha,
  input  wire logic [4:0]  nbits,
  input  wire logic [15:0] tx_word,
  output logic      [15:0] rx_word
);
  int k;

  initial miso = 1'b0;

  // select fall reloads; phase 0 puts the msb out at once
  always @(negedge ss_n)
  begin
    k = 0;
    if (!pha)
      miso = tx_word[nbits-1];
  end

  // released line must not keep its last level
  always @(posedge ss_n) miso = ~miso;

  // leading edge is the one leaving the polarity level
  always @(sclk)
    if (!ss_n)
    begin
      if ((sclk != pol) ^ pha)
        rx_word = {rx_word[14:0], mosi};
      else if (pha || k + 1 < nbits)
      begin
        k = pha ? k % nbits : k + 1;
        miso = tx_word[nbits-1-k];
        if (pha)
          k = k + 1;
      end
    end
endmodule : sfs_slave_model

// ==== sim/tb.sv ====
`timescale 1ns/1ps

module tb;
  import sfs_pkg::*;
  localparam int H = 4; // half bit in clk cycles, divider 3
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [32:0] r;
  logic        sclk_in, fs_in, ext_d, use_ext, m_miso, fs_prev;
  logic        sclk_o, fs_o, txd, txoe_n, ckoe_n, pol, pha;
  logic [4:0]  nb;
  logic [15:0] s_word, m_rx, w, w2, mask;
  int          errors, checks, rises;

  sfs_spi_frame_sequencer sfs_spi_frame_sequencer_inst (
    .clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_clock_in(sclk_in), .frame_select_in(fs_in),
    .rx_serial_line(use_ext ? ext_d : m_miso),
    .serial_clock_out(sclk_o), .frame_select_out(fs_o),
    .tx_serial_line(txd), .tx_pad_enable_n(txoe_n),
    .clock_pad_enable_n(ckoe_n));

  sfs_slave_model sfs_slave_model_inst (
    .sclk(sclk_o), .ss_n(fs_o), .mosi(txd), .miso(m_miso), .pol(pol),
    .pha(pha), .nbits(nb), .tx_word(s_word), .rx_word(m_rx));

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; returns {pslverr, prdata} taken at the ready edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [32:0] rr);
    int n = 0;
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n++ < 50)
      @(posedge clk);
    if (pready !== 1'b1)
      errors++;
    rr = {pslverr, prdata};
    {psel, penable} <= 2'b00;
  endtask : apb

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic final_report;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // select rises, to tell pulsed from held select between words
  always @(posedge clk)
  begin
    if (fs_prev === 1'b0 && fs_o === 1'b1)
      rises++;
    fs_prev <= fs_o;
  end

  // watchdog, far beyond the thousand or so cycles the tests need
  initial
  begin
    #2_000_000;
    errors++;
    final_report();
  end

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, sclk_in, ext_d} = '0;
    {use_ext, pol, pha, s_word, rst_n} = '0;
    {fs_in, fs_prev, nb} = {2'b11, 5'd8};
    {errors, checks, rises} = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    tick(1);
    chk({fs_o, txd, txoe_n, ckoe_n, sclk_o}, 5'b10100);
    apb(0, CTRL_OFS, 32'h0, r);
    chk(r, {17'h0_0000, CTRL_RST});
    apb(0, 12'h010, 32'h0, r);
    chk(r, {1'b1, 32'h0000_0000});
    $display("test reset and map done");
    // every polarity and phase, two words back to back
    for (int m = 0; m < 4; m++)
    begin
      {pha, pol} = 2'(m);
      nb = 5'(m == 1 ? 16 : 4 + 4 * m);
      mask = 16'hFFFF >> (16 - nb);
      {w, w2, s_word} = {16'hB4D2 & mask, 16'h4B2D & mask, 16'h5A3C & mask};
      apb(1, CTRL_OFS, 32'(32'h0301 | (m << 2) | ((nb - 1) << 4)), r);
      tick(2);
      chk(sclk_o, pol);
      rises = 0;
      apb(1, TXD_OFS, {16'h0000, w}, r);
      for (int k = 0; k < 100 && fs_o !== 1'b0; k++)
        tick(1);
      chk({fs_o, txoe_n}, 2'b00);
      tick(H);
      chk({txd, sclk_o}, {w[nb-1], pol ^ pha});
      tick(H);
      chk(sclk_o, pol ^ !pha);
      apb(1, TXD_OFS, {16'h0000, w2}, r);
      for (int k = 0; k < 400; k++)
      begin
        apb(0, STAT_OFS, 32'h0, r);
        if (r[1:0] === 2'b00 && fs_o === 1'b1)
          break;
      end
      chk(33'(rises), pha ? 33'd1 : 33'd2);
      chk(m_rx & mask, w2);
      apb(0, RXD_OFS, 32'h0, r);
      chk(r, {17'h0_0000, s_word});
      chk({fs_o, txd, txoe_n, sclk_o}, {3'b101, pol});
      $display("test master mode %0d done", m);
    end
    // slave: bench is the external master, link clock 800 ns
    // modes 0 and 3, so both slave phase paths are exercised
    use_ext <= 1'b1;
    for (int m = 0; m < 4; m += 3)
    begin
      {pha, pol} = 2'(m);
      sclk_in <= pol;
      apb(1, CTRL_OFS, 32'(32'h0373 | (m << 2)), r);
      tick(2);
      chk({ckoe_n, fs_o}, 2'b11);
      apb(1, TXD_OFS, 32'h0000_00C6, r);
      w = 16'h0039;
      @(posedge clk);
      {fs_in, ext_d} <= {1'b0, w[7]};
      for (int b = 7; b >= 0; b--)
      begin
        repeat (H) @(posedge clk);
        if (!pha)
          w2[b] = txd;
        {sclk_in, ext_d} <= {~pol, pha ? w[b] : ext_d};
        repeat (H) @(posedge clk);
        if (pha)
          w2[b] = txd;
        sclk_in <= pol;
        if (!pha)
          ext_d <= b > 0 ? w[b-1] : ~w[0];
      end
      repeat (H) @(posedge clk);
      {fs_in, ext_d} <= {1'b1, w[0]};
      chk(txoe_n, 1'b0);
      chk(w2[7:0], 8'hC6);
      for (int k = 0; k < 50; k++)
      begin
        apb(0, STAT_OFS, 32'h0, r);
        if (r[2] === 1'b1)
          break;
      end
      apb(0, RXD_OFS, 32'h0, r);
      chk(r, {17'h0_0000, w});
      $display("test slave mode %0d done", m);
    end
    // disabled port must not start even with data pending
    use_ext <= 1'b0;
    apb(1, CTRL_OFS, 32'h0000_0370, r);
    apb(1, TXD_OFS, 32'h0000_00AA, r);
    tick(40);
    chk({fs_o, txoe_n, ckoe_n}, 3'b110);
    $display("test disabled start done");
    final_report();
  end
endmodule : tb
